// file: hw/cpuexe_core.sv
// Instruction execute unit: accumulator, flags, program counter, stack
module cpuexe_core (
  // Clock and reset
  input  wire logic                       mclk_in,
  input  wire logic                       rst_n_in,
  // Instruction stream
  input  wire logic [15:0]                instr_in,
  input  wire logic                       instr_valid_in,
  // File register read data for the current address
  input  wire logic [7:0]                 fdata_in,
  // Table pointer and program memory read data
  input  wire logic [15:0]                table_pointer_in,
  input  wire logic [15:0]                rom_data_in,
  // File register bus
  output cpuexe_pkg::cpuexe_fbus_t        fbus_out,
  output logic [cpuexe_pkg::FADDR_W-1:0]  faddr_out,
  // Core state
  output logic [cpuexe_pkg::PC_W-1:0]     pc_out,
  output logic [15:0]                     rom_addr_out,
  output logic [7:0]                      acc_out,
  output logic [4:0]                      flags_out,
  output logic                            global_irq_enable_out,
  output logic                            power_down_out,
  output logic                            busy_out
);

  ////////////////////////////////////////////////////////////////////////
  // Decode
  cpuexe_pkg::cpuexe_state_t state;
  logic [cpuexe_pkg::FADDR_W-1:0] faddr;
  logic [7:0]  lit;
  logic [3:0]  fop;
  logic        dbit;
  logic        is_file;
  logic        go;
  logic [cpuexe_pkg::PC_W-1:0] top;
  logic [cpuexe_pkg::PC_W-1:0] pc;
  logic [7:0]  acc;
  logic [4:0]  flg;

  assign go      = instr_valid_in && state == cpuexe_pkg::CPUEXE_RUN
                   && !power_down_out;
  assign faddr   = {instr_in[15:14], instr_in[6:0]};
  assign lit     = instr_in[7:0];
  assign fop     = instr_in[11:8];
  assign dbit    = instr_in[7];
  assign is_file = instr_in[13:12] == 2'b00 && instr_in[15:14] != 2'b00
                   || instr_in[13:8] inside {6'h02, 6'h06, 6'h08, 6'h0C,
                                             6'h0D, 6'h0E}
                   || instr_in[13:7] == 7'h01;

  logic is_jump;
  logic is_call;
  logic is_ret;
  logic is_interrupt_exit;
  logic is_exit_with_literal;
  logic is_tabl;
  logic is_tabh;
  logic is_sleep;
  assign is_jump  = instr_in[13:11] == cpuexe_pkg::JOP_JUMP;
  assign is_call  = instr_in[13:11] == cpuexe_pkg::JOP_CALL;
  assign is_ret   = instr_in == cpuexe_pkg::OP_RET;
  assign is_interrupt_exit  = instr_in == cpuexe_pkg::OP_INTERRUPT_EXIT;
  assign is_exit_with_literal = instr_in[15:8] == cpuexe_pkg::LIT_EXIT_WITH_LITERAL;
  assign is_tabl  = instr_in == cpuexe_pkg::OP_TABLE_READ_LOWER;
  assign is_tabh  = instr_in == cpuexe_pkg::OP_TABLE_READ_UPPER;
  assign is_sleep = instr_in == cpuexe_pkg::OP_SLEEP;

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic
  logic [8:0] sub_res;
  logic [4:0] sub_lo;
  logic [7:0] sub_a;
  logic       sub_lit;
  assign sub_lit = instr_in[15:8] == cpuexe_pkg::LIT_LITERAL_MINUS_ACC;
  assign sub_a   = sub_lit ? lit : fdata_in;
  assign sub_res = {1'b0, sub_a} + {1'b0, ~acc} + 9'h001;
  assign sub_lo  = {1'b0, sub_a[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

  logic [7:0] next_res;
  logic       res_z;
  logic       wr_acc;
  logic       wr_file;
  logic       upd_z;
  logic       upd_c;
  logic       upd_dc;
  logic       next_c;

  always_comb begin
    next_res = 8'h00;
    wr_acc   = 1'b0;
    wr_file  = 1'b0;
    upd_z    = 1'b0;
    upd_c    = 1'b0;
    upd_dc   = 1'b0;
    next_c   = flg[cpuexe_pkg::FLG_C];
    if (go && instr_in[13:12] == 2'b00 && !is_ret && !is_interrupt_exit
        && !is_tabl && !is_tabh && instr_in != cpuexe_pkg::OP_IDLE) begin
      unique case (fop)
        cpuexe_pkg::FOP_ACC_TO_FILE_STORE: begin
          if (dbit) begin
            next_res = acc;
            wr_file  = 1'b1;
          end
        end
        cpuexe_pkg::FOP_FILE_MINUS_ACC: begin
          next_res = sub_res[7:0];
          upd_z    = 1'b1;
          upd_c    = 1'b1;
          upd_dc   = 1'b1;
          next_c   = sub_res[8];
          wr_acc   = !dbit;
          wr_file  = dbit;
        end
        cpuexe_pkg::FOP_FILE_XOR: begin
          next_res = acc ^ fdata_in;
          upd_z    = 1'b1;
          wr_acc   = !dbit;
          wr_file  = dbit;
        end
        cpuexe_pkg::FOP_FILE_MOVE: begin
          next_res = fdata_in;
          upd_z    = 1'b1;
          wr_acc   = !dbit;
        end
        cpuexe_pkg::FOP_RRX: begin
          next_res = {flg[cpuexe_pkg::FLG_C], fdata_in[7:1]};
          upd_c    = 1'b1;
          next_c   = fdata_in[0];
          wr_acc   = !dbit;
          wr_file  = dbit;
        end
        cpuexe_pkg::FOP_RLX: begin
          next_res = {fdata_in[6:0], flg[cpuexe_pkg::FLG_C]};
          upd_c    = 1'b1;
          next_c   = fdata_in[7];
          wr_acc   = !dbit;
          wr_file  = dbit;
        end
        cpuexe_pkg::FOP_NIBBLE_EXCHANGE: begin
          next_res = {fdata_in[3:0], fdata_in[7:4]};
          wr_acc   = !dbit;
          wr_file  = dbit;
        end
        default: begin
          next_res = 8'h00;
        end
      endcase
    end else if (go && instr_in[15:12] == 4'h1) begin
      unique case (instr_in[15:8])
        cpuexe_pkg::LIT_EXIT_WITH_LITERAL,
        cpuexe_pkg::LIT_LITERAL_LOAD: begin
          next_res = lit;
          wr_acc   = 1'b1;
        end
        cpuexe_pkg::LIT_LITERAL_XOR: begin
          next_res = acc ^ lit;
          upd_z    = 1'b1;
          wr_acc   = 1'b1;
        end
        cpuexe_pkg::LIT_LITERAL_MINUS_ACC: begin
          next_res = sub_res[7:0];
          upd_z    = 1'b1;
          upd_c    = 1'b1;
          upd_dc   = 1'b1;
          next_c   = sub_res[8];
          wr_acc   = 1'b1;
        end
        default: begin
          next_res = 8'h00;
        end
      endcase
    end
  end
  assign res_z = next_res == 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Accumulator and flags
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc <= 8'h00;
    end else if (wr_acc) begin
      acc <= next_res;
    end else if (state == cpuexe_pkg::CPUEXE_TAB) begin
      acc <= rom_addr_out[15] ? rom_data_in[15:8] : rom_data_in[7:0];
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flg <= cpuexe_pkg::STATUS_RST[4:0];
    end else begin
      if (upd_z) begin
        flg[cpuexe_pkg::FLG_Z] <= res_z;
      end
      if (upd_c) begin
        flg[cpuexe_pkg::FLG_C] <= next_c;
      end
      if (upd_dc) begin
        flg[cpuexe_pkg::FLG_DC] <= sub_lo[4];
      end
      if (go && is_sleep) begin
        flg[cpuexe_pkg::FLG_PD] <= 1'b0;
        flg[cpuexe_pkg::FLG_TO] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter, phases, stack
  logic push;
  logic pop;
  assign push = go && is_call;
  assign pop  = go && (is_ret || is_interrupt_exit || is_exit_with_literal);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= cpuexe_pkg::CPUEXE_RUN;
      pc    <= cpuexe_pkg::PC_RST;
    end else begin
      unique case (state)
        cpuexe_pkg::CPUEXE_RUN: begin
          if (go) begin
            if (is_jump || is_call) begin
              pc    <= {instr_in[15:14], instr_in[10:0]};
              state <= cpuexe_pkg::CPUEXE_WAIT;
            end else if (pop) begin
              pc    <= top;
              state <= cpuexe_pkg::CPUEXE_WAIT;
            end else if (is_tabl || is_tabh) begin
              pc    <= pc + 1'b1;
              state <= cpuexe_pkg::CPUEXE_TAB;
            end else begin
              pc    <= pc + 1'b1;
            end
          end
        end
        cpuexe_pkg::CPUEXE_WAIT,
        cpuexe_pkg::CPUEXE_TAB: begin
          state <= cpuexe_pkg::CPUEXE_RUN;
        end
      endcase
    end
  end

  cpuexe_stack u_stack (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .push_in      (push),
    .pop_in       (pop),
    .push_data_in (pc + 1'b1),
    .top_out      (top)
  );

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      global_irq_enable_out <= 1'b0;
      power_down_out        <= 1'b0;
    end else begin
      if (go && is_interrupt_exit) begin
        global_irq_enable_out <= 1'b1;
      end
      if (go && is_sleep) begin
        power_down_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered file bus and table address; faddr, pc, acc, flags and busy outputs assigned directly
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fbus_out     <= '0;
      rom_addr_out <= 16'h0000;
    end else begin
      fbus_out.we    <= wr_file;
      fbus_out.addr  <= faddr;
      fbus_out.wdata <= next_res;
      if (go && (is_tabl || is_tabh)) begin
        rom_addr_out <= {is_tabh, table_pointer_in[14:0]};
      end
    end
  end

  assign faddr_out = faddr;
  assign pc_out    = pc;
  assign acc_out   = acc;
  assign flags_out = flg;
  assign busy_out  = state != cpuexe_pkg::CPUEXE_RUN;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_two_cycle;
    go && (is_jump || pop) ##1 busy_out;
  endsequence

  a_jump_target: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    go && is_jump |=> pc == $past({instr_in[15:14], instr_in[10:0]}))
    else $error("jump target wrong");
  a_two_cycles: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    s_two_cycle |=> !busy_out)
    else $error("two-cycle timing wrong");
  a_irq_enable: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    go && is_interrupt_exit |=> global_irq_enable_out && busy_out)
    else $error("irq enable not set");
  a_lit_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    go && instr_in[15:8] == cpuexe_pkg::LIT_LITERAL_LOAD
    |=> acc == $past(lit) && $stable(flg))
    else $error("literal load wrong");
  a_idle_nochg: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    go && instr_in == cpuexe_pkg::OP_IDLE
    |=> $stable(acc) && $stable(flg) && !busy_out)
    else $error("idle changed state");
  a_sub_carry: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    go && sub_lit |=> flg[cpuexe_pkg::FLG_C] == ($past(lit) >= $past(acc)))
    else $error("subtract carry wrong");
  a_rot_left: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    go && fop == cpuexe_pkg::FOP_RLX && instr_in[13:12] == 2'b00
    |=> flg[cpuexe_pkg::FLG_C] == $past(fdata_in[7]))
    else $error("rotate carry wrong");
  a_sleep_entry: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    go && is_sleep |=> power_down_out && !flg[cpuexe_pkg::FLG_PD])
    else $error("sleep entry wrong");
  a_table_read: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    go && (is_tabl || is_tabh) |=> busy_out ##1 !busy_out)
    else $error("table read timing wrong");

endmodule : cpuexe_core

// file: hw/cpuexe_pkg.sv
// Package: opcodes, field positions, flag positions and sizes for the executor
package cpuexe_pkg;

  localparam int PC_W    = 13;
  localparam int FADDR_W = 9;
  localparam int STACK_D = 8;

  // Flag positions in the flag outputs
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_PD = 3;
  localparam int FLG_TO = 4;

  // Fixed whole-word opcodes
  localparam logic [15:0] OP_IDLE  = 16'h0000;
  localparam logic [15:0] OP_RET   = 16'h0040;
  localparam logic [15:0] OP_INTERRUPT_EXIT  = 16'h0060;
  localparam logic [15:0] OP_TABLE_READ_LOWER = 16'h0050;
  localparam logic [15:0] OP_TABLE_READ_UPPER = 16'h0058;
  localparam logic [15:0] OP_SLEEP = 16'h1E03;

  // Literal group: bits 15:8
  localparam logic [7:0] LIT_EXIT_WITH_LITERAL = 8'h18;
  localparam logic [7:0] LIT_LITERAL_LOAD = 8'h19;
  localparam logic [7:0] LIT_LITERAL_XOR = 8'h1D;
  localparam logic [7:0] LIT_LITERAL_MINUS_ACC = 8'h1F;

  // File group: bits 13:8 with bits 13:12 = 00, field is bits 11:8
  localparam logic [3:0] FOP_ACC_TO_FILE_STORE = 4'h0;
  localparam logic [3:0] FOP_FILE_MINUS_ACC = 4'h2;
  localparam logic [3:0] FOP_FILE_XOR = 4'h6;
  localparam logic [3:0] FOP_FILE_MOVE  = 4'h8;
  localparam logic [3:0] FOP_RRX   = 4'hC;
  localparam logic [3:0] FOP_RLX   = 4'hD;
  localparam logic [3:0] FOP_NIBBLE_EXCHANGE = 4'hE;

  // Jump and call: bits 13:11
  localparam logic [2:0] JOP_CALL = 3'h4;
  localparam logic [2:0] JOP_JUMP = 3'h5;

  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [7:0]      STATUS_RST = 8'h18;

  // Execution phases
  typedef enum logic [2:0] {
    CPUEXE_RUN  = 3'b001,
    CPUEXE_WAIT = 3'b010,
    CPUEXE_TAB  = 3'b100
  } cpuexe_state_t;

  // File bus request
  typedef struct packed {
    logic               we;
    logic [FADDR_W-1:0] addr;
    logic [7:0]         wdata;
  } cpuexe_fbus_t;

endpackage : cpuexe_pkg

// file: hw/cpuexe_stack.sv
// Return stack memory with registered top-of-stack
module cpuexe_stack #(
  parameter int DEPTH = cpuexe_pkg::STACK_D,
  parameter int W     = cpuexe_pkg::PC_W
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  // Control
  input  wire logic         push_in,
  input  wire logic         pop_in,
  input  wire logic [W-1:0] push_data_in,
  // Top entry
  output logic      [W-1:0] top_out
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] ptr;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr <= '0;
    end else if (push_in) begin
      ptr <= ptr + 1'b1;
    end else if (pop_in) begin
      ptr <= ptr - 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (push_in) begin
      mem[ptr] <= push_data_in;
    end
  end

  // Registered read of the entry below the pointer
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      top_out <= '0;
    end else if (push_in) begin
      top_out <= push_data_in;
    end else if (pop_in) begin
      top_out <= mem[PW'(ptr - 2'd2)];
    end else begin
      top_out <= mem[PW'(ptr - 1'b1)];
    end
  end

endmodule : cpuexe_stack

// file: test/cpuexe_mem.sv
// Far-side model: file register space and program memory
module cpuexe_mem (
  // Clock
  input  wire logic                           mclk_in,
  // File register bus
  input  wire cpuexe_pkg::cpuexe_fbus_t       fbus_in,
  input  wire logic [cpuexe_pkg::FADDR_W-1:0] faddr_in,
  output logic      [7:0]                     fdata_out,
  // Program memory
  input  wire logic [15:0]                    rom_addr_in,
  output logic      [15:0]                    rom_data_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] regs [0:511];

  ////////////////////////////////////////////////////////////////////////////
  // File registers, read combinationally, written on the pulse
  assign fdata_out = regs[faddr_in];
  always @(posedge mclk_in) begin
    if (fbus_in.we === 1'b1) begin
      regs[fbus_in.addr] <= fbus_in.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table word pattern: upper byte differs from lower
  assign rom_data_out = {rom_addr_in[7:0] ^ 8'hC3, rom_addr_in[7:0]};
endmodule : cpuexe_mem

// file: test/tb_cpu_instruction_execute_part.sv
// Testbench for the instruction execute unit
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_cpu_instruction_execute_part;
  timeunit 1ns;
  timeprecision 1ns;

  logic                           mclk_in, rst_n_in, valid, global_irq_enable, pd, busy;
  logic [15:0]                    instr, tp, rom_data, rom_addr;
  logic [7:0]                     fdata, acc;
  logic [8:0]                     faddr;
  logic [12:0]                    pc;
  logic [4:0]                     flags, sf;
  cpuexe_pkg::cpuexe_fbus_t       fbus;
  int                             errors, total_checks, nb;

  cpuexe_core dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .instr_in(instr),
    .instr_valid_in(valid), .fdata_in(fdata), .table_pointer_in(tp),
    .rom_data_in(rom_data), .fbus_out(fbus), .faddr_out(faddr), .pc_out(pc),
    .rom_addr_out(rom_addr), .acc_out(acc), .flags_out(flags),
    .global_irq_enable_out(global_irq_enable), .power_down_out(pd), .busy_out(busy));
  cpuexe_mem mem (.mclk_in(mclk_in), .fbus_in(fbus), .faddr_in(faddr),
    .fdata_out(fdata), .rom_addr_in(rom_addr), .rom_data_out(rom_data));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  function automatic logic [15:0] fw(input logic [3:0] op, input logic d,
                                     input logic [8:0] f);
    fw = {f[8:7], 2'b00, op, d, f[6:0]};
  endfunction : fw

  task automatic exec(input logic [15:0] w);
    nb = 0;
    @(negedge mclk_in);
    instr = w;
    valid = 1'b1;
    @(negedge mclk_in);
    valid = 1'b0;
    while (busy === 1'b1 && nb < 8) begin
      nb++;
      @(negedge mclk_in);
    end
    if (nb >= 8) begin
      errors++;
      $display("unexpected at %0t: busy stuck", $time);
      final_report();
    end
  endtask : exec

  task automatic poke(input logic [8:0] a, input logic [7:0] v);
    @(negedge mclk_in);
    mem.regs[a] = v;
  endtask : poke

  task automatic ld(input logic [7:0] k);
    exec({cpuexe_pkg::LIT_LITERAL_LOAD, k});
  endtask : ld

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_literal;
    sf = flags;
    ld(8'hB5);
    `CHK(acc, 8'hB5)
    `CHK(flags, sf)
    exec({cpuexe_pkg::LIT_LITERAL_XOR, 8'hAF});
    `CHK({flags[2], acc}, 9'h01A)
    exec({cpuexe_pkg::LIT_LITERAL_XOR, 8'h1A});
    `CHK({flags[2], acc}, 9'h100)
    ld(8'h25);
    exec({cpuexe_pkg::LIT_LITERAL_MINUS_ACC, 8'h15});
    `CHK({flags[2:0], acc}, 11'h2F0)
    exec({cpuexe_pkg::LIT_LITERAL_MINUS_ACC, 8'hF0});
    `CHK({flags[2:0], acc}, 11'h700)
  endtask : t_literal

  task automatic t_file;
    poke(9'h1A5, 8'hC2);
    exec(fw(cpuexe_pkg::FOP_FILE_MOVE, 1'b0, 9'h1A5));
    `CHK({flags[2], acc}, 9'h0C2)
    ld(8'h4F);
    sf = flags;
    exec(fw(cpuexe_pkg::FOP_ACC_TO_FILE_STORE, 1'b1, 9'h0F3));
    @(negedge mclk_in);
    `CHK(mem.regs[9'h0F3], 8'h4F)
    `CHK(flags, sf)
    poke(9'h111, 8'h00);
    exec(fw(cpuexe_pkg::FOP_FILE_MOVE, 1'b1, 9'h111));
    @(negedge mclk_in);
    `CHK({flags[2], mem.regs[9'h111]}, 9'h100)
    exec(fw(cpuexe_pkg::FOP_FILE_MOVE, 1'b1, 9'h1A5));
    `CHK({flags[2], acc}, 9'h04F)
    poke(9'h0A0, 8'hA5);
    sf = flags;
    exec(fw(cpuexe_pkg::FOP_NIBBLE_EXCHANGE, 1'b0, 9'h0A0));
    `CHK({flags, acc}, {sf, 8'h5A})
    exec(fw(cpuexe_pkg::FOP_NIBBLE_EXCHANGE, 1'b1, 9'h0A0));
    @(negedge mclk_in);
    `CHK(mem.regs[9'h0A0], 8'h5A)
  endtask : t_file

  task automatic sub_case(input logic [7:0] f, input logic [10:0] e);
    poke(9'h155, f);
    ld(8'h02);
    exec(fw(cpuexe_pkg::FOP_FILE_MINUS_ACC, 1'b1, 9'h155));
    @(negedge mclk_in);
    `CHK({flags[2:0], mem.regs[9'h155]}, e)
  endtask : sub_case

  task automatic t_sub_xor;
    sub_case(8'h03, 11'h301);
    sub_case(8'h02, 11'h700);
    sub_case(8'h01, 11'h0FF);
    poke(9'h020, 8'hAF);
    ld(8'hB5);
    exec(fw(cpuexe_pkg::FOP_FILE_XOR, 1'b1, 9'h020));
    @(negedge mclk_in);
    `CHK({flags[2], acc, mem.regs[9'h020]}, 17'h0B51A)
  endtask : t_sub_xor

  task automatic t_rotate;
    poke(9'h130, 8'hE6);
    poke(9'h131, 8'h01);
    ld(8'h00);
    exec({cpuexe_pkg::LIT_LITERAL_MINUS_ACC, 8'h01});
    `CHK(flags[0], 1'b1)
    exec(fw(cpuexe_pkg::FOP_RRX, 1'b1, 9'h131));
    @(negedge mclk_in);
    `CHK({flags[0], mem.regs[9'h131]}, 9'h180)
    exec(fw(cpuexe_pkg::FOP_RLX, 1'b0, 9'h130));
    `CHK({flags[0], acc}, 9'h1CD)
    exec(fw(cpuexe_pkg::FOP_RRX, 1'b0, 9'h130));
    `CHK({flags[0], acc}, 9'h0F3)
  endtask : t_rotate

  task automatic t_flow;
    logic [12:0] p;
    p = pc;
    sf = flags;
    exec(cpuexe_pkg::OP_IDLE);
    `CHK({nb[1:0], pc, flags}, {2'd0, p + 13'd1, sf})
    exec({2'b10, cpuexe_pkg::JOP_JUMP, 11'h234});
    `CHK({nb[1:0], pc}, {2'd1, 13'h1234})
    exec({2'b00, cpuexe_pkg::JOP_CALL, 11'h100});
    `CHK({nb[1:0], pc}, {2'd1, 13'h0100})
    exec(cpuexe_pkg::OP_RET);
    `CHK({nb[1:0], pc}, {2'd1, 13'h1235})
    exec({2'b00, cpuexe_pkg::JOP_CALL, 11'h200});
    exec(cpuexe_pkg::OP_INTERRUPT_EXIT);
    `CHK({nb[1:0], global_irq_enable, pc}, {2'd1, 1'b1, 13'h1236})
    exec({2'b01, cpuexe_pkg::JOP_CALL, 11'h300});
    exec({cpuexe_pkg::LIT_EXIT_WITH_LITERAL, 8'h77});
    `CHK({nb[1:0], acc, pc}, {2'd1, 8'h77, 13'h1237})
  endtask : t_flow

  task automatic t_table;
    tp = 16'h0234;
    exec(cpuexe_pkg::OP_TABLE_READ_LOWER);
    `CHK({nb[1:0], acc}, {2'd1, 8'h34})
    exec(cpuexe_pkg::OP_TABLE_READ_UPPER);
    `CHK({nb[1:0], acc}, {2'd1, 8'hF7})
  endtask : t_table

  task automatic t_sleep;
    logic [7:0] a;
    a = acc;
    exec(cpuexe_pkg::OP_SLEEP);
    `CHK({nb[1:0], pd, flags[4:3]}, 5'b00110)
    ld(8'h99);
    `CHK(acc, a)
  endtask : t_sleep

  ////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  initial begin
    rst_n_in = 1'b0;
    valid = 1'b0;
    instr = 16'h0000;
    tp = 16'h0000;
    errors = 0;
    total_checks = 0;
    repeat (12) @(negedge mclk_in);
    rst_n_in = 1'b1;
    `CHK({pc, acc, flags, global_irq_enable, pd}, {13'h0000, 8'h00, 5'h18, 2'b00})
    t_literal();
    t_file();
    t_sub_xor();
    t_rotate();
    t_flow();
    t_table();
    t_sleep();
    final_report();
  end
endmodule : tb_cpu_instruction_execute_part
